/* hdl/pnir_params.svh */
// What this block does
// [RULE1] Local next-page flag, writable, resets zero
// [RULE2] Message-page flag resets one; bit 14 zero
// [RULE3] Local second-acknowledge flag, writable, resets zero
// [RULE4] Local toggle read-only, shows previous sent toggle
// [RULE5] Eleven-bit writable message field, resets 001
// [RULE6] Partner page read-only, captured, acknowledge on receipt
// [RULE7] Partner second-acknowledge shows partner can act
// [RULE8] Partner toggle reads inverse of previous toggle
// [RULE9] Sixteen-bit receive error counter, read-only
// [RULE10] Eight interrupt enables in upper byte
// [RULE11] Eight event flags in lower byte
// [RULE12] Reading interrupt register clears event flags
// [RULE13] Interrupt asserted while enabled flag set
// [RULE14] Polarity bit selects interrupt pin level
// [RULE15] Crossover disable bit, writable, resets zero
// [RULE16] Energy detect bit shows receive signal
// [RULE17] Force-link bit bypasses link control
// [RULE18] Power-saving bit, writable, resets one
// [RULE19] Jabber enable bit gates jabber counter
// [RULE20] Auto-negotiation complete bit shows finish
`ifndef PNIR_PARAMS_SVH
`define PNIR_PARAMS_SVH
`define PNIR_ADDR_W        5
`define PNIR_OFF_LNP       5'h07
`define PNIR_OFF_PNP       5'h08
`define PNIR_OFF_RXERR     5'h15
`define PNIR_OFF_INT       5'h1b
`define PNIR_OFF_CTRL      5'h1f
`define PNIR_LNP_NEXT      15
`define PNIR_LNP_MSGPG     13
`define PNIR_LNP_ACK2      12
`define PNIR_LNP_TOGGLE    11
`define PNIR_MSG_RST       11'h001
`define PNIR_CTRL_XOVER    13
`define PNIR_CTRL_ENERGY   12
`define PNIR_CTRL_FORCE    11
`define PNIR_CTRL_PSAVE    10
`define PNIR_CTRL_POL      9
`define PNIR_CTRL_JAB      8
`define PNIR_CTRL_ANDONE   7
`endif

/* hdl/pnir_pkg.sv */
`default_nettype none
package pnir_pkg;
	typedef logic [15:0] pnir_word_t;
	typedef logic [7:0]  pnir_evt_t;
endpackage
`default_nettype wire

/* hdl/pnir_regs.sv */
`include "pnir_params.svh"
`default_nettype none
module pnir_regs
	import pnir_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	input  wire logic [`PNIR_ADDR_W-1:0]  reg_addr,
	input  wire logic [15:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [15:0]                   reg_rdata,
	input  wire logic                     tx_word_sent,
	input  wire logic                     tx_toggle,
	input  wire logic                     rx_word_valid,
	input  wire logic [15:0]              rx_word,
	input  wire logic                     receive_error_tally,
	input  wire logic [7:0]               event_pulse,
	input  wire logic                     energy_present,
	input  wire logic                     an_complete,
	output logic                          irq_pin,
	output logic                          xover_disable,
	output logic                          force_link,
	output logic                          power_save_en,
	output logic                          jabber_count_en
);
	logic [15:0] rd_data_reg;
	logic        lnp_next_reg;
	logic        lnp_msgpg_reg;
	logic        lnp_ack2_reg;
	logic        lnp_toggle_reg;
	logic [10:0] lnp_msg_reg;
	pnir_word_t  pnp_reg;
	pnir_word_t  rxerr_reg;
	pnir_evt_t   int_en_reg;
	pnir_evt_t   int_flag_reg;
	pnir_evt_t   int_flag_next;
	logic        xover_reg;
	logic        force_reg;
	logic        psave_reg;
	logic        pol_reg;
	logic        jab_reg;
	logic        an_done_reg;
	logic [1:0]  energy_sync_reg;
	logic [1:0]  an_sync_reg;
	logic [1:0]  receive_error_tally_sync_reg;
	logic        receive_error_tally_prev_reg;
	logic        irq_active;

	function automatic logic hit(input logic [`PNIR_ADDR_W-1:0] off);
		hit = (reg_addr == off);
	endfunction

	// Status levels from the analog side arrive asynchronously
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			energy_sync_reg <= 2'h0;
			an_sync_reg     <= 2'h0;
			receive_error_tally_sync_reg   <= 2'h0;
			receive_error_tally_prev_reg   <= 1'b0;
			an_done_reg     <= 1'b0;
		end else begin
			energy_sync_reg <= {energy_sync_reg[0], energy_present};
			an_sync_reg     <= {an_sync_reg[0], an_complete};
			receive_error_tally_sync_reg   <= {receive_error_tally_sync_reg[0], receive_error_tally};
			receive_error_tally_prev_reg   <= receive_error_tally_sync_reg[1];
			an_done_reg     <= an_sync_reg[1]; // RULE20
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lnp_next_reg  <= 1'b0;
			lnp_msgpg_reg <= 1'b1;
			lnp_ack2_reg  <= 1'b0;
			lnp_msg_reg   <= `PNIR_MSG_RST;
		end else if (reg_wr && hit(`PNIR_OFF_LNP)) begin
			lnp_next_reg  <= reg_wdata[`PNIR_LNP_NEXT]; // RULE1
			lnp_msgpg_reg <= reg_wdata[`PNIR_LNP_MSGPG]; // RULE2
			lnp_ack2_reg  <= reg_wdata[`PNIR_LNP_ACK2]; // RULE3
			lnp_msg_reg   <= reg_wdata[10:0]; // RULE5
		end
	end

	// Toggle follows the last word actually sent, not software
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			lnp_toggle_reg <= 1'b0;
		else if (tx_word_sent)
			lnp_toggle_reg <= tx_toggle; // RULE4
	end

	// Partner word captured as received, except ack bit 14 set and toggle bit 11 taken from the inverted local toggle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			pnp_reg <= 16'h0000;
		else if (rx_word_valid) begin
			pnp_reg     <= rx_word; // RULE6 RULE7
			pnp_reg[14] <= 1'b1; // RULE6
			pnp_reg[11] <= ~lnp_toggle_reg; // RULE8
		end
	end

	// Counter saturates rather than wrapping to zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rxerr_reg <= 16'h0000;
		else if (receive_error_tally_sync_reg[1] && !receive_error_tally_prev_reg && rxerr_reg != 16'hffff)
			rxerr_reg <= rxerr_reg + 16'h0001; // RULE9
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			int_en_reg <= 8'h00;
		else if (reg_wr && hit(`PNIR_OFF_INT))
			int_en_reg <= reg_wdata[15:8]; // RULE10
	end

	// New events win over the clear on read
	always_comb begin
		int_flag_next = int_flag_reg;
		if (reg_rd && hit(`PNIR_OFF_INT))
			int_flag_next = 8'h00; // RULE12
		int_flag_next = int_flag_next | event_pulse; // RULE11
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			int_flag_reg <= 8'h00;
		else
			int_flag_reg <= int_flag_next;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			xover_reg <= 1'b0;
			force_reg <= 1'b0;
			psave_reg <= 1'b1;
			pol_reg   <= 1'b0;
			jab_reg   <= 1'b1;
		end else if (reg_wr && hit(`PNIR_OFF_CTRL)) begin
			xover_reg <= reg_wdata[`PNIR_CTRL_XOVER]; // RULE15
			force_reg <= reg_wdata[`PNIR_CTRL_FORCE]; // RULE17
			psave_reg <= reg_wdata[`PNIR_CTRL_PSAVE]; // RULE18
			pol_reg   <= reg_wdata[`PNIR_CTRL_POL]; // RULE14
			jab_reg   <= reg_wdata[`PNIR_CTRL_JAB]; // RULE19
		end
	end

	assign irq_active = |(int_flag_reg & int_en_reg); // RULE13

	// Pin from a flop so polarity changes cannot glitch it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			irq_pin <= 1'b1;
		else
			irq_pin <= pol_reg ? irq_active : ~irq_active; // RULE14
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rd_data_reg <= 16'h0000;
		else if (reg_rd) begin
			case (reg_addr)
				`PNIR_OFF_LNP:
					rd_data_reg <= {lnp_next_reg, 1'b0, lnp_msgpg_reg,
						lnp_ack2_reg, lnp_toggle_reg, lnp_msg_reg}; // RULE2
				`PNIR_OFF_PNP:   rd_data_reg <= pnp_reg;
				`PNIR_OFF_RXERR: rd_data_reg <= rxerr_reg;
				`PNIR_OFF_INT:   rd_data_reg <= {int_en_reg, int_flag_reg};
				`PNIR_OFF_CTRL:
					rd_data_reg <= {2'h0, xover_reg, energy_sync_reg[1],
						force_reg, psave_reg, pol_reg, jab_reg,
						an_done_reg, 7'h00}; // RULE16 RULE20
				default:         rd_data_reg <= 16'h0000;
			endcase
		end
	end

	assign reg_rdata       = rd_data_reg;
	assign xover_disable   = xover_reg;
	assign force_link      = force_reg;
	assign power_save_en   = psave_reg;
	assign jabber_count_en = jab_reg;
endmodule // pnir_regs
`default_nettype wire

/* tb/pnir_host.sv */
`default_nettype none
module pnir_host (
	input wire logic	core_clk,
	output logic [4:0]	reg_addr,
	output logic [15:0]	reg_wdata,
	output logic	reg_wr,
	output logic	reg_rd,
	input wire logic [15:0]	reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// Entered just after an edge, so reads may run back to back
	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
endmodule // pnir_host
`default_nettype wire

/* tb/pnir_monitor.sv */
`default_nettype none
module pnir_monitor (
	input wire logic	core_clk,
	input wire logic	rst_n,
	input wire logic [4:0]	reg_addr,
	input wire logic [15:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [15:0]	reg_rdata,
	input wire logic	tx_word_sent,
	input wire logic	tx_toggle,
	input wire logic	rx_word_valid,
	input wire logic [15:0]	rx_word,
	input wire logic	receive_error_tally,
	input wire logic [7:0]	event_pulse,
	input wire logic	energy_present,
	input wire logic	an_complete,
	input wire logic	irq_pin,
	input wire logic	xover_disable,
	input wire logic	force_link,
	input wire logic	power_save_en,
	input wire logic	jabber_count_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic	pol_reg;
	wire	rd_int = reg_rd && reg_addr == 5'h1b && !event_pulse;
	wire	[3:0] ctl_w = {reg_wdata[13], reg_wdata[11:10], reg_wdata[8]};
	wire	[3:0] ctl_o = {xover_disable, force_link, power_save_en,
		jabber_count_en};
	// Mirror of the polarity bit, needed to judge the pin level
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n) pol_reg <= 1'b0;
		else if (reg_wr && reg_addr == 5'h1f) pol_reg <= reg_wdata[9];
	a_flags_clear: assert property (
		rd_int ##1 rd_int |=> reg_rdata[7:0] == 8'h00) else $error("flags kept");
	a_unmapped_zero: assert property (reg_rd && !(reg_addr inside
		{5'h07, 5'h08, 5'h15, 5'h1b, 5'h1f}) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	a_lnp_rsv: assert property (
		reg_rd && reg_addr == 5'h07 |=> !reg_rdata[14]) else $error("bit 14");
	a_lnp_toggle: assert property (
		reg_rd && reg_addr == 5'h07 && $past(tx_word_sent)
		|=> reg_rdata[11] == $past(tx_toggle, 2)) else $error("local toggle");
	a_pnp_ack: assert property (
		reg_rd && reg_addr == 5'h08 && $past(rx_word_valid)
		|=> reg_rdata[14]) else $error("partner ack");
	a_irq_level: assert property (
		reg_rd && reg_addr == 5'h1b |=> irq_pin ==
		($past(pol_reg) == |(reg_rdata[15:8] & reg_rdata[7:0])))
		else $error("irq level");
	a_ctrl_out: assert property (
		reg_wr && reg_addr == 5'h1f |=> ctl_o == $past(ctl_w))
		else $error("control outputs");
	c_int_read: cover property (rd_int);
	c_event: cover property (event_pulse != 8'h00);
	c_irq: cover property ($fell(irq_pin));
endmodule // pnir_monitor
bind pnir_regs pnir_monitor mon (.core_clk, .rst_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .tx_word_sent, .tx_toggle, .rx_word_valid,
	.rx_word, .receive_error_tally, .event_pulse, .energy_present,
	.an_complete, .irq_pin, .xover_disable, .force_link, .power_save_en,
	.jabber_count_en);
`default_nettype wire

/* tb/tb_phy_nextpage_interrupt_regs.sv */
`default_nettype none
module tb_phy_nextpage_interrupt_regs import pnir_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic	core_clk = 0, rst_n = 0, tx_word_sent = 0, tx_toggle = 0;
	logic	rx_word_valid = 0, receive_error_tally = 0;
	logic	energy_present = 0, an_complete = 0, reg_wr, reg_rd;
	logic	irq_pin, xover_disable, force_link, power_save_en, jabber_count_en;
	logic	[4:0] reg_addr;
	pnir_word_t	reg_wdata, reg_rdata, q, rx_word = '0;
	pnir_evt_t	event_pulse = '0;
	int	bad_count = 0, n_tests = 0, cyc = 0;
	pnir_regs dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .tx_word_sent, .tx_toggle, .rx_word_valid,
		.rx_word, .receive_error_tally, .event_pulse, .energy_present,
		.an_complete, .irq_pin, .xover_disable, .force_link,
		.power_save_en, .jabber_count_en);
	pnir_host host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	initial forever #5 core_clk = ~core_clk;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge core_clk) if (++cyc == 3000) begin
		bad_count++;
		print_verdict();
	end
	task automatic chk(input string n, input pnir_word_t e, s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic rc(input logic [4:0] a, input pnir_word_t e);
		host.rd(a, q);
		chk("rdata", e, q);
	endtask
	task automatic t_reset();
		rc(5'h07, 16'h2001);
		rc(5'h08, 16'h0000);
		rc(5'h15, 16'h0000);
		rc(5'h1b, 16'h0000);
		rc(5'h1f, 16'h0500);
		rc(5'h03, 16'h0000);
	endtask
	task automatic t_pages();
		host.wr(5'h07, 16'hffff);
		rc(5'h07, 16'hb7ff);
		@(posedge core_clk) {tx_word_sent, tx_toggle} <= 2'b11;
		@(posedge core_clk) tx_word_sent <= 1'b0;
		rc(5'h07, 16'hbfff);
		host.wr(5'h08, 16'hffff);
		rc(5'h08, 16'h0000);
		@(posedge core_clk) {rx_word_valid, rx_word} <= {1'b1, 16'h9a55};
		@(posedge core_clk) rx_word_valid <= 1'b0;
		rc(5'h08, 16'hd255);
	endtask
	task automatic t_rxerr();
		repeat (6) begin
			repeat (5) @(posedge core_clk);
			receive_error_tally <= ~receive_error_tally;
		end
		repeat (5) @(posedge core_clk);
		host.wr(5'h15, 16'h1234);
		rc(5'h15, 16'h0003);
	endtask
	task automatic t_ctrl();
		host.wr(5'h1f, 16'hffff);
		rc(5'h1f, 16'h2f00);
		chk("outs", 16'hf, {xover_disable, force_link, power_save_en,
			jabber_count_en});
		chk("irq", 16'h0, irq_pin);
		@(posedge core_clk) {energy_present, an_complete} <= 2'b11;
		repeat (5) @(posedge core_clk);
		host.wr(5'h1f, 16'h0000);
		rc(5'h1f, 16'h1080);
	endtask
	task automatic t_int();
		host.wr(5'h1b, 16'hffff);
		rc(5'h1b, 16'hff00);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk) event_pulse <= 8'h01 << i;
			@(posedge core_clk) event_pulse <= 8'h00;
			@(posedge core_clk) #1 chk("irq", 16'h0, irq_pin);
			rc(5'h1b, 16'hff00 | (16'h1 << i));
			rc(5'h1b, 16'hff00);
		end
		host.wr(5'h1b, 16'h0000);
		@(posedge core_clk) event_pulse <= 8'h80;
		@(posedge core_clk) event_pulse <= 8'h00;
		repeat (2) @(posedge core_clk) #1 chk("irq", 16'h1, irq_pin);
		rc(5'h1b, 16'h0080);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_pages();
		t_rxerr();
		t_ctrl();
		t_int();
		print_verdict();
	end
endmodule // tb_phy_nextpage_interrupt_regs
`default_nettype wire
